// [verilog/spbl_pkg.sv]
/*
  Constants and types shared by the partition lock controller, its
  request-side partner and the lock link between them.
  Assumes a single core clock domain and one fundamental reset.
*/
package spbl_pkg;
  // tlp kind codes carried on the lock link
  localparam logic [2:0] KIND_MWR = 3'h0;
  localparam logic [2:0] KIND_MRDLK = 3'h1;
  localparam logic [2:0] KIND_UNLOCK = 3'h2;
  localparam logic [2:0] KIND_CPLDLK = 3'h3;
  localparam logic [2:0] KIND_CPLLK = 3'h4;
  localparam logic [2:0] KIND_OTHER = 3'h5;
  localparam logic [2:0] KIND_MSG = 3'h6;
  // port numbering: port 0 is the upstream switch port
  localparam int NPORTS = 4;
  localparam logic [1:0] UP_PORT = 2'h0;
  localparam logic [1:0] NO_PORT_IDX = 2'h0;
  localparam logic [2:0] VC_LOCKED = 3'h0;
  // lock sequencer states, one-hot
  typedef enum logic [3:0] {
    SPBL_IDLE = 4'h1,
    SPBL_DN_LOCK = 4'h2,
    SPBL_BUS_LOCK = 4'h4,
    SPBL_DRAIN = 4'h8
  } spbl_state_t;
  typedef logic [NPORTS-1:0] spbl_pmask_t;
endpackage : spbl_pkg

// [verilog/spbl_if.sv]
/*
  Lock link between the switch partition lock controller and the agent
  that offers TLP headers to it. Holds no logic.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface spbl_if;
  // tlp offered at an ingress port
  logic tlp_valid;
  logic [2:0] tlp_kind;
  logic [1:0] tlp_src;
  logic [1:0] tlp_dst;
  logic [2:0] tlp_vc;
  logic tlp_posted;
  logic tlp_ready;
  // queue state seen by the controller
  logic [3:0] posted_pend;
  // forwarded tlp from controller
  logic fwd_valid;
  logic [2:0] fwd_kind;
  logic [1:0] fwd_dst;
  // lock state and hot-plug enables
  logic [3:0] port_locked;
  logic bus_locked;
  logic [3:0] hp_enable;

  modport dev (
    input tlp_valid, tlp_kind, tlp_src, tlp_dst, tlp_vc, tlp_posted,
    input posted_pend,
    output tlp_ready, fwd_valid, fwd_kind, fwd_dst, port_locked,
    output bus_locked, hp_enable
  );
  modport host (
    output tlp_valid, tlp_kind, tlp_src, tlp_dst, tlp_vc, tlp_posted,
    output posted_pend,
    input tlp_ready, fwd_valid, fwd_kind, fwd_dst, port_locked,
    input bus_locked, hp_enable
  );
endinterface : spbl_if

// [verilog/spbl_block_chk.sv]
/*
  Combinational hold decision for one offered tlp against the current
  port lock flags. Assumes the lock flags come from the same clock.
*/
`timescale 1ns/1ps
module spbl_block_chk (
  // offered tlp
  input wire logic [1:0] src,
  input wire logic [1:0] dst,
  input wire logic [2:0] vc,
  // lock state
  input wire logic [3:0] port_locked,
  input wire logic [1:0] locked_dn,
  // decision
  output logic hold
);
  // only vc0 traffic to a locked port is held; the partner of the lock
  // may still reach it
  always_comb begin
    hold = 1'b0;
    if (vc == spbl_pkg::VC_LOCKED && port_locked[dst]) begin
      if (dst == spbl_pkg::UP_PORT)
        hold = (src != locked_dn);
      else
        hold = (src != spbl_pkg::UP_PORT);
    end
  end
endmodule : spbl_block_chk

// [verilog/spbl_lock_ctl.sv]
/*
  Lock controller for one switch partition: tracks locked reads, locked
  completions and unlock, keeps per-port lock flags and holds vc0 tlps
  aimed at locked ports. Assumes the host keeps offering a held tlp
  (valid stays high) until tlp_ready, and reports posted backlog per
  destination on posted_pend.
*/
`timescale 1ns/1ps
module spbl_lock_ctl (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // lock link
  spbl_if.dev lnk,
  // per-port configuration
  input wire logic [3:0] dn_port_mode,
  input wire logic [3:0] hot_plug_capable_bit,
  // sideband register path status
  output logic sideband_ok
);
  spbl_pkg::spbl_state_t state, next_state;
  spbl_pkg::spbl_pmask_t port_locked, next_port_locked;
  logic [1:0] locked_dn, next_locked_dn;
  logic fwd_valid, next_fwd_valid;
  logic [2:0] fwd_kind, next_fwd_kind;
  logic [1:0] fwd_dst, next_fwd_dst;
  logic [3:0] hp_enable, next_hp_enable;
  logic bus_locked, next_bus_locked;
  logic next_sideband_ok;
  logic hold;
  logic wait_posted;
  logic take;
  logic is_kind_unlock;

  spbl_block_chk u_chk (
    .src(lnk.tlp_src),
    .dst(lnk.tlp_dst),
    .vc(lnk.tlp_vc),
    .port_locked(port_locked),
    .locked_dn(locked_dn),
    .hold(hold)
  );

  // locked read and completion wait behind posted traffic of their path
  always_comb begin
    wait_posted = 1'b0;
    if (lnk.tlp_valid && lnk.tlp_kind == spbl_pkg::KIND_MRDLK &&
        lnk.tlp_src == spbl_pkg::UP_PORT)
      wait_posted = lnk.posted_pend[lnk.tlp_dst];
    if (lnk.tlp_valid && lnk.tlp_kind == spbl_pkg::KIND_CPLDLK &&
        lnk.tlp_dst == spbl_pkg::UP_PORT)
      wait_posted = lnk.posted_pend[spbl_pkg::UP_PORT];
    // an unlock that ends a lock, complete or not, drains first
    if (lnk.tlp_valid && lnk.tlp_kind == spbl_pkg::KIND_UNLOCK &&
        (state == spbl_pkg::SPBL_BUS_LOCK ||
         state == spbl_pkg::SPBL_DN_LOCK))
      wait_posted = lnk.posted_pend[locked_dn];
    // posted writes never wait on ordering, only on the lock itself
    if (lnk.tlp_posted)
      wait_posted = 1'b0;
  end

  // held tlps stay offered until the lock drops; none is discarded.
  // ready is combinational so an unheld tlp goes without a bubble;
  // the cost is a path from the offer fields through the hold decision
  assign take = lnk.tlp_valid && !hold && !wait_posted;
  assign is_kind_unlock = lnk.tlp_kind == spbl_pkg::KIND_UNLOCK;

  // lock sequencer next values
  always_comb begin
    next_state = state;
    next_port_locked = port_locked;
    next_locked_dn = locked_dn;
    next_fwd_valid = take;
    next_fwd_kind = lnk.tlp_kind;
    next_fwd_dst = lnk.tlp_dst;
    case (state)
      spbl_pkg::SPBL_IDLE: begin
        // a second locked read is never started while one is open
        if (take && lnk.tlp_kind == spbl_pkg::KIND_MRDLK &&
            lnk.tlp_src == spbl_pkg::UP_PORT &&
            lnk.tlp_dst != spbl_pkg::UP_PORT) begin
          next_port_locked[lnk.tlp_dst] = 1'b1;
          next_locked_dn = lnk.tlp_dst;
          next_state = spbl_pkg::SPBL_DN_LOCK;
        end
        if (take && is_kind_unlock)
          next_fwd_valid = 1'b0;
      end
      spbl_pkg::SPBL_DN_LOCK: begin
        if (take && lnk.tlp_kind == spbl_pkg::KIND_CPLDLK &&
            lnk.tlp_src == locked_dn &&
            lnk.tlp_dst == spbl_pkg::UP_PORT) begin
          next_port_locked[spbl_pkg::UP_PORT] = 1'b1;
          next_state = spbl_pkg::SPBL_BUS_LOCK;
        end
        // unlock from the root before the lock completed aborts the
        // sequence; one from any other port is ignored
        if (take && is_kind_unlock &&
            lnk.tlp_src == spbl_pkg::UP_PORT) begin
          next_fwd_dst = locked_dn;
          next_port_locked = '0;
          next_locked_dn = spbl_pkg::NO_PORT_IDX;
          next_state = spbl_pkg::SPBL_IDLE;
        end else if (take && is_kind_unlock) begin
          next_fwd_valid = 1'b0;
        end
      end
      spbl_pkg::SPBL_BUS_LOCK: begin
        // reads, completions and writes pass without touching state
        if (take && is_kind_unlock &&
            lnk.tlp_src == spbl_pkg::UP_PORT) begin
          next_fwd_dst = locked_dn;
          next_state = spbl_pkg::SPBL_DRAIN;
        end else if (take && is_kind_unlock) begin
          // only the root's unlock counts; others are swallowed
          next_fwd_valid = 1'b0;
        end
      end
      spbl_pkg::SPBL_DRAIN: begin
        // one cycle so the forwarded unlock leads released traffic
        next_port_locked = '0;
        next_locked_dn = spbl_pkg::NO_PORT_IDX;
        next_state = spbl_pkg::SPBL_IDLE;
      end
      default: begin
        // an illegal state code falls back to no lock at all
        next_state = spbl_pkg::SPBL_IDLE;
        next_port_locked = '0;
        next_locked_dn = spbl_pkg::NO_PORT_IDX;
      end
    endcase
  end

  // hot-plug controller enable per port
  always_comb begin
    next_hp_enable = dn_port_mode & hot_plug_capable_bit;
  end

  // registers; reset drops every lock and frees held traffic
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= spbl_pkg::SPBL_IDLE;
      port_locked <= '0;
      locked_dn <= spbl_pkg::NO_PORT_IDX;
      fwd_valid <= 1'b0;
      fwd_kind <= spbl_pkg::KIND_MWR;
      fwd_dst <= spbl_pkg::UP_PORT;
      hp_enable <= '0;
    end else begin
      state <= next_state;
      port_locked <= next_port_locked;
      locked_dn <= next_locked_dn;
      fwd_valid <= next_fwd_valid;
      fwd_kind <= next_fwd_kind;
      fwd_dst <= next_fwd_dst;
      hp_enable <= next_hp_enable;
    end
  end

  // status flags; bus_locked is a flop so the agent sees a clean level
  always_comb begin
    next_bus_locked = (next_state == spbl_pkg::SPBL_BUS_LOCK);
    next_sideband_ok = 1'b1; // sideband path never gated by the lock
  end

  // status registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_locked <= 1'b0;
      sideband_ok <= 1'b0;
    end else begin
      bus_locked <= next_bus_locked;
      sideband_ok <= next_sideband_ok;
    end
  end

  assign lnk.tlp_ready = take;
  assign lnk.fwd_valid = fwd_valid;
  assign lnk.fwd_kind = fwd_kind;
  assign lnk.fwd_dst = fwd_dst;
  assign lnk.port_locked = port_locked;
  assign lnk.bus_locked = bus_locked;
  assign lnk.hp_enable = hp_enable;
endmodule : spbl_lock_ctl

// [verilog/spbl_agent.sv]
/*
  Traffic agent standing for the root complex and the legacy endpoint:
  offers one tlp at a time from a user request and holds it until the
  controller takes it. Filters traffic the far rules forbid while
  bus-locked. Assumes user request fields are stable with req_valid.
*/
`timescale 1ns/1ps
module spbl_agent (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // lock link
  spbl_if.host lnk,
  // user request
  input wire logic req_valid,
  input wire logic [2:0] req_kind,
  input wire logic [1:0] req_src,
  input wire logic [1:0] req_dst,
  input wire logic [2:0] req_vc,
  input wire logic [3:0] req_posted_pend,
  // user answer
  output logic req_busy,
  output logic req_reject,
  output logic req_done
);
  logic off_valid, next_off_valid;
  logic [2:0] off_kind, next_off_kind;
  logic [1:0] off_src, next_off_src;
  logic [1:0] off_dst, next_off_dst;
  logic [2:0] off_vc, next_off_vc;
  logic next_reject, next_done;
  logic legal;

  // only legal traffic may be offered to a bus-locked partition
  always_comb begin
    legal = 1'b1;
    if (lnk.bus_locked) begin
      if (req_src == spbl_pkg::UP_PORT)
        legal = (req_kind == spbl_pkg::KIND_MWR ||
                 req_kind == spbl_pkg::KIND_MRDLK ||
                 req_kind == spbl_pkg::KIND_UNLOCK) &&
                (req_dst == spbl_pkg::UP_PORT ||
                 lnk.port_locked[req_dst]);
      else if (lnk.port_locked[req_src])
        legal = (req_kind == spbl_pkg::KIND_CPLLK ||
                 req_kind == spbl_pkg::KIND_CPLDLK ||
                 req_kind == spbl_pkg::KIND_MSG);
    end
  end

  // offer register next values
  always_comb begin
    next_off_valid = off_valid;
    next_off_kind = off_kind;
    next_off_src = off_src;
    next_off_dst = off_dst;
    next_off_vc = off_vc;
    next_reject = 1'b0;
    next_done = 1'b0;
    if (off_valid && lnk.tlp_ready) begin
      next_off_valid = 1'b0;
      next_done = 1'b1;
    end else if (!off_valid && req_valid) begin
      if (legal) begin
        next_off_valid = 1'b1;
        next_off_kind = req_kind;
        next_off_src = req_src;
        next_off_dst = req_dst;
        next_off_vc = req_vc;
      end else
        next_reject = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      off_valid <= 1'b0;
      off_kind <= spbl_pkg::KIND_MWR;
      off_src <= spbl_pkg::UP_PORT;
      off_dst <= spbl_pkg::UP_PORT;
      off_vc <= spbl_pkg::VC_LOCKED;
      req_reject <= 1'b0;
      req_done <= 1'b0;
    end else begin
      off_valid <= next_off_valid;
      off_kind <= next_off_kind;
      off_src <= next_off_src;
      off_dst <= next_off_dst;
      off_vc <= next_off_vc;
      req_reject <= next_reject;
      req_done <= next_done;
    end
  end

  // busy mirrors the offer flop
  assign req_busy = off_valid;
  assign lnk.tlp_valid = off_valid;
  assign lnk.tlp_kind = off_kind;
  assign lnk.tlp_src = off_src;
  assign lnk.tlp_dst = off_dst;
  assign lnk.tlp_vc = off_vc;
  assign lnk.tlp_posted = (off_kind == spbl_pkg::KIND_MWR);
  assign lnk.posted_pend = req_posted_pend;
endmodule : spbl_agent

// [tb/spbl_lock_chk.sv]
/*
  Checker for the lock link: lock state and hold relations.
  Assumes it sits beside the link, one clock, rst active high.
*/
`timescale 1ns/1ps
module spbl_lock_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // offered tlp
  input wire logic tlp_valid,
  input wire logic [2:0] tlp_kind,
  input wire logic [1:0] tlp_src,
  input wire logic [1:0] tlp_dst,
  input wire logic [2:0] tlp_vc,
  input wire logic tlp_ready,
  input wire logic [3:0] posted_pend,
  // forwarded tlp and lock state
  input wire logic fwd_valid,
  input wire logic [2:0] fwd_kind,
  input wire logic [3:0] port_locked,
  input wire logic bus_locked
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // short helpers keep each property on a few lines
  wire take = tlp_valid && tlp_ready;
  wire k_unl = tlp_kind == spbl_pkg::KIND_UNLOCK;
  wire k_mrd = tlp_kind == spbl_pkg::KIND_MRDLK;
  wire k_cpl = tlp_kind == spbl_pkg::KIND_CPLDLK;
  wire k_mwr = tlp_kind == spbl_pkg::KIND_MWR;
  // vc0 offer to a locked port from a port that is not its partner
  wire dst_up = tlp_dst == spbl_pkg::UP_PORT;
  wire blk = tlp_vc == spbl_pkg::VC_LOCKED && port_locked[tlp_dst] &&
    (dst_up ? !port_locked[tlp_src] : tlp_src != spbl_pkg::UP_PORT);
  sequence s_unl_take;
    bus_locked && take && k_unl && tlp_src == spbl_pkg::UP_PORT;
  endsequence
  sequence s_unl_done;
    fwd_valid && fwd_kind == spbl_pkg::KIND_UNLOCK && !bus_locked
      ##1 port_locked == 4'h0;
  endsequence
  property p_fwd;
    take && !k_unl |=> fwd_valid && fwd_kind == $past(tlp_kind);
  endproperty
  a_fwd: assert property (p_fwd) else $error("take not forwarded");
  property p_mrd;
    take && k_mrd && tlp_src == spbl_pkg::UP_PORT && !dst_up &&
      port_locked == 4'h0 |=>
      port_locked == (4'h1 << $past(tlp_dst));
  endproperty
  a_mrd: assert property (p_mrd) else $error("read lock wrong");
  property p_hold;
    tlp_valid && blk |-> !tlp_ready;
  endproperty
  a_hold: assert property (p_hold) else $error("locked tlp taken");
  property p_pass;
    tlp_valid && k_mwr && (tlp_vc != 3'h0 || !port_locked[tlp_dst])
      |-> tlp_ready;
  endproperty
  a_pass: assert property (p_pass) else $error("free write held");
  property p_mrd_pend;
    tlp_valid && k_mrd && posted_pend[tlp_dst] |-> !tlp_ready;
  endproperty
  a_mrd_pend: assert property (p_mrd_pend) else $error("read passed");
  property p_cpl_pend;
    tlp_valid && k_cpl && dst_up && posted_pend[0] |-> !tlp_ready;
  endproperty
  a_cpl_pend: assert property (p_cpl_pend) else $error("cpl passed");
  property p_bus;
    take && k_cpl && dst_up && !bus_locked && port_locked[tlp_src]
      |=> bus_locked && port_locked[0];
  endproperty
  a_bus: assert property (p_bus) else $error("no bus lock");
  property p_keep;
    bus_locked && take && !k_unl |=> bus_locked && $stable(port_locked);
  endproperty
  a_keep: assert property (p_keep) else $error("lock changed");
  property p_unlock;
    s_unl_take |=> s_unl_done;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock wrong");
  property p_drain;
    bus_locked && tlp_valid && k_unl &&
      (posted_pend & port_locked & 4'hE) != 4'h0 |-> !tlp_ready;
  endproperty
  a_drain: assert property (p_drain) else $error("unlock early");
  property p_reset;
    $fell(rst) |-> port_locked == 4'h0 && !bus_locked;
  endproperty
  a_reset: assert property (p_reset) else $error("lock kept");
  property p_one;
    $countones(port_locked & 4'hE) <= 1;
  endproperty
  a_one: assert property (p_one) else $error("two ports locked");
endmodule : spbl_lock_chk

// [tb/testbench.sv]
/*
  Self-checking bench: agent and lock controller joined by the link.
  Assumes one 40 MHz clock and one request at a time.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end
module testbench;
  // stimulus and observed outputs
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic [2:0] req_kind = 3'h0;
  logic [1:0] req_src = 2'h0;
  logic [1:0] req_dst = 2'h0;
  logic [2:0] req_vc = 3'h0;
  logic [3:0] pend = 4'h0;
  logic [3:0] dn_mode = 4'hE;
  logic [3:0] hp_cap = 4'h7; // port 0 capable but upstream: stays off
  logic req_busy, req_reject, req_done, sideband_ok;
  logic [1:0] got;
  logic [2:0] fk;
  logic [1:0] fd;
  int n_fwd = 0;
  int nf = 0;
  int fail_count = 0;
  int n_compared = 0;
  // kinds sent while bus-locked, with the answer each should get
  logic [2:0] kk [7] = '{spbl_pkg::KIND_CPLLK, spbl_pkg::KIND_MRDLK,
    spbl_pkg::KIND_MWR, spbl_pkg::KIND_MSG, spbl_pkg::KIND_OTHER,
    spbl_pkg::KIND_MWR, spbl_pkg::KIND_MWR};
  logic [1:0] ks [7] = '{2'h2, 2'h0, 2'h0, 2'h2, 2'h0, 2'h0, 2'h2};
  logic [1:0] kd [7] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h2, 2'h1, 2'h0};
  logic [1:0] ke [7] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
  spbl_if lnk ();
  spbl_lock_ctl u_spbl_lock_ctl (.clock(clock), .rst(rst),
    .lnk(lnk.dev), .dn_port_mode(dn_mode),
    .hot_plug_capable_bit(hp_cap), .sideband_ok(sideband_ok));
  spbl_agent u_spbl_agent (.clock(clock), .rst(rst), .lnk(lnk.host),
    .req_valid(req_valid), .req_kind(req_kind), .req_src(req_src),
    .req_dst(req_dst), .req_vc(req_vc), .req_posted_pend(pend),
    .req_busy(req_busy), .req_reject(req_reject), .req_done(req_done));
  spbl_lock_chk u_chk (.clock(clock), .rst(rst),
    .tlp_valid(lnk.tlp_valid), .tlp_kind(lnk.tlp_kind),
    .tlp_src(lnk.tlp_src), .tlp_dst(lnk.tlp_dst), .tlp_vc(lnk.tlp_vc),
    .tlp_ready(lnk.tlp_ready), .posted_pend(lnk.posted_pend),
    .fwd_valid(lnk.fwd_valid), .fwd_kind(lnk.fwd_kind),
    .port_locked(lnk.port_locked), .bus_locked(lnk.bus_locked));
  // 25 ns clock
  initial begin
    forever #12.5 clock = ~clock;
  end
  // record each forwarded tlp
  always @(posedge clock) begin
    if (lnk.fwd_valid === 1'b1) begin
      n_fwd++;
      fk = lnk.fwd_kind;
      fd = lnk.fwd_dst;
    end
  end
  // closing task, shared with the watchdog
  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  // wait for done or reject; one spare cycle lets lock flags settle
  task automatic wt(input int lim);
    got = 2'h0;
    repeat (lim) begin
      if (got == 2'h0) begin
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        if (req_done === 1'b1) got = 2'h1;
        if (req_reject === 1'b1) got = 2'h2;
      end
    end
    @(posedge clock);
    #1;
  endtask : wt
  // one user request, dropped after the edge that takes it
  task automatic rq(input logic [2:0] k, input logic [1:0] s,
    input logic [1:0] d, input logic [2:0] v, input int lim);
    @(posedge clock);
    #1;
    req_valid = 1'b1;
    req_kind = k;
    req_src = s;
    req_dst = d;
    req_vc = v;
    wt(lim);
  endtask : rq
  // hang guard, far beyond the 125 or so cycles needed
  initial begin
    repeat (3000) @(posedge clock);
    fail_count++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    #1 rst = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK("hp_enable", 4'h6, lnk.hp_enable)
    `CHK("sideband", 1'b1, sideband_ok)
    rq(spbl_pkg::KIND_MWR, 2'h0, 2'h1, 3'h0, 10);
    `CHK("mwr", 2'h1, got)
    pend = 4'h4;
    rq(spbl_pkg::KIND_MRDLK, 2'h0, 2'h2, 3'h0, 6);
    `CHK("mrd held", 2'h0, got)
    pend = 4'h0;
    wt(10);
    `CHK("dn lock", 4'h4, lnk.port_locked)
    `CHK("fwd mrd", spbl_pkg::KIND_MRDLK, fk)
    rq(spbl_pkg::KIND_MRDLK, 2'h0, 2'h1, 3'h0, 10);
    `CHK("2nd lock", 4'h4, lnk.port_locked)
    `CHK("2nd dst", 2'h1, fd)
    rq(spbl_pkg::KIND_MWR, 2'h1, 2'h2, 3'h1, 10);
    `CHK("vc1", 2'h1, got)
    rq(spbl_pkg::KIND_MWR, 2'h3, 2'h0, 3'h0, 10);
    `CHK("to up", 2'h1, got)
    pend = 4'h1;
    rq(spbl_pkg::KIND_CPLDLK, 2'h2, 2'h0, 3'h0, 6);
    `CHK("cpl held", 2'h0, got)
    pend = 4'h0;
    wt(10);
    `CHK("up lock", 4'h5, lnk.port_locked)
    `CHK("bus lock", 1'b1, lnk.bus_locked)
    for (int i = 0; i < 7; i++) begin
      rq(kk[i], ks[i], kd[i], 3'h0, 10);
      `CHK("locked kind", ke[i], got)
      `CHK("still", 1'b1, lnk.bus_locked)
    end
    pend = 4'h4;
    rq(spbl_pkg::KIND_UNLOCK, 2'h0, 2'h2, 3'h0, 6);
    `CHK("unl held", 2'h0, got)
    pend = 4'h0;
    wt(10);
    `CHK("fwd unl", spbl_pkg::KIND_UNLOCK, fk)
    `CHK("unl dst", 2'h2, fd)
    `CHK("released", 4'h0, lnk.port_locked)
    nf = n_fwd;
    rq(spbl_pkg::KIND_UNLOCK, 2'h0, 2'h1, 3'h0, 10);
    `CHK("idle unl", nf, n_fwd)
    rq(spbl_pkg::KIND_MRDLK, 2'h0, 2'h3, 3'h0, 10);
    rq(spbl_pkg::KIND_CPLDLK, 2'h3, 2'h0, 3'h0, 10);
    `CHK("lock 3", 4'h9, lnk.port_locked)
    nf = n_fwd;
    rq(spbl_pkg::KIND_MWR, 2'h1, 2'h3, 3'h0, 20);
    `CHK("blocked", nf, n_fwd)
    `CHK("kept", 1'b1, lnk.tlp_valid)
    `CHK("busy", 1'b1, req_busy)
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    `CHK("rst lock", 4'h0, lnk.port_locked)
    `CHK("rst bus", 1'b0, lnk.bus_locked)
    rq(spbl_pkg::KIND_MWR, 2'h1, 2'h3, 3'h0, 10);
    `CHK("after rst", 2'h1, got)
    end_sim();
  end
endmodule : testbench
